// File: gmp_message_port.sv
`timescale 1ns/10ps
// What this block does
// - Talker marks last byte with EOI low.
// - Command bytes under ATN low always acknowledged.
// - Data bytes handshaked only when addressed listener.
// - Accept LF+EOI, LF CR+EOI, or EOI alone.
// - Semicolon splits commands within one message.
// - Response ends with line feed under EOI.
// - Status byte in serial poll without EOI.
// - Poll enable, one status byte, poll disable.
// - Set bit 4 when response is ready.
// - Other command before read: flush, error, clear.
// - Clear message flag once response fully sent.
// - Failed command: timeout error, set message flag.
// - Listen address plus 32, talk plus 64.
// - Three-wire handshake on DAV, NRFD, NDAC.
// - Interface clear drops addressing and poll mode.
// - Active-low lines, DIO1 is least significant.
module gmp_message_port (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       clkEn,
    input  wire logic [4:0] busAddr,
    input  wire logic [7:0] dioN_i,
    output logic      [7:0] dioN_o,
    output logic            dioN_oe,
    input  wire logic       davN_i,
    output logic            davN_o,
    output logic            davN_oe,
    input  wire logic       nrfdN_i,
    output logic            nrfdN_o,
    output logic            nrfdN_oe,
    input  wire logic       ndacN_i,
    output logic            ndacN_o,
    output logic            ndacN_oe,
    input  wire logic       eoiN_i,
    output logic            eoiN_o,
    output logic            eoiN_oe,
    input  wire logic       atnN_i,
    input  wire logic       ifcN_i,
    output logic      [7:0] rxData,
    output logic            rxValid,
    input  wire logic       rxReady,
    output logic            cmdEnd,
    output logic            msgEnd,
    input  wire logic [7:0] txData,
    input  wire logic       txLast,
    input  wire logic       txValid,
    output logic            txReady,
    input  wire logic       respReady,
    input  wire logic       execFail,
    input  wire logic [7:0] statusIn,
    output logic            outFlush,
    output logic            errValid,
    output logic      [9:0] errCode,
    output logic            listenAddr_q,
    output logic            talkAddr_q,
    output logic            pollMode_q,
    output logic            mav_q
);
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_RXACK = 4'b0010,
        ST_TXDAV = 4'b0100,
        ST_TXEND = 4'b1000
    } gmp_state_t;

    gmp_state_t state_q;
    logic [7:0] dioS;
    logic       davS, nrfdS, ndacS, eoiS, atnS, ifcS;
    logic [4:0] addr_q;
    logic [7:0] byte_q;
    logic       eoiLatch_q;
    logic       atnLatch_q;
    logic       prevLf_q;
    logic       sentLf_q;
    logic [8:0] bufOutData;
    logic       bufOutValid;
    logic       bufInReady;
    logic       rxTake;
    logic       ifcActive;

    // Bus levels are inverted once here so the rest works in true logic.
    gmp_sync #(.WIDTH(14)) u_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .clkEn    (clkEn),
        .resetVal (14'h3FFF),
        .asyncIn  ({dioN_i, davN_i, nrfdN_i, ndacN_i, eoiN_i, atnN_i, ifcN_i}),
        .syncOut  ({dioS, davS, nrfdS, ndacS, eoiS, atnS, ifcS})
    );

    logic [7:0] dioT;
    logic       davT, nrfdT, ndacT, eoiT, atnT;
    assign dioT      = ~dioS;
    assign davT      = ~davS;
    assign nrfdT     = ~nrfdS;
    assign ndacT     = ~ndacS;
    assign eoiT      = ~eoiS;
    assign atnT      = ~atnS;
    assign ifcActive = ~ifcS;

    function automatic logic isTerm(input logic [7:0] b);
        isTerm = (b == gmp_pkg::CHAR_LF) || (b == gmp_pkg::CHAR_CR);
    endfunction : isTerm

    // Data mode bytes are held back while the buffer is full, so NRFD stays true.
    logic dataByte;
    assign dataByte = !atnLatch_q && listenAddr_q;
    assign rxTake   = (state_q == ST_IDLE) && davT && (atnT || (listenAddr_q && bufInReady));

    gmp_buf2 #(.WIDTH(9)) u_buf (
        .core_clk (core_clk),
        .reset    (reset),
        .clkEn    (clkEn),
        .inData   ({eoiLatch_q, byte_q}),
        .inValid  ((state_q == ST_RXACK) && dataByte && !davT),
        .inReady  (bufInReady),
        .outData  (bufOutData),
        .outValid (bufOutValid),
        .outReady (rxReady)
    );

    always_ff @(posedge core_clk) begin
        if (reset) begin
            addr_q <= gmp_pkg::ADDR_RESET;
        end else if (clkEn && busAddr <= gmp_pkg::ADDR_MAX) begin
            addr_q <= busAddr;
        end
    end

    logic [7:0] listenByte, talkByte;
    assign listenByte = gmp_pkg::LISTEN_BASE + {3'h0, addr_q};
    assign talkByte   = gmp_pkg::TALK_BASE + {3'h0, addr_q};

    always_ff @(posedge core_clk) begin
        if (reset) begin
            listenAddr_q <= 1'b0;
            talkAddr_q   <= 1'b0;
            pollMode_q   <= 1'b0;
        end else if (clkEn) begin
            if (ifcActive) begin
                listenAddr_q <= 1'b0;
                talkAddr_q   <= 1'b0;
                pollMode_q   <= 1'b0;
            end else if (rxTake && atnT) begin
                if (dioT == listenByte) begin
                    listenAddr_q <= 1'b1;
                end else if (dioT == gmp_pkg::CMD_UNL) begin
                    listenAddr_q <= 1'b0;
                end
                if (dioT == talkByte) begin
                    talkAddr_q <= 1'b1;
                end else if (dioT == gmp_pkg::CMD_UNT || (dioT[7:5] == 3'h2)) begin
                    talkAddr_q <= 1'b0;
                end
                if (dioT == gmp_pkg::CMD_SPE) begin
                    pollMode_q <= 1'b1;
                end else if (dioT == gmp_pkg::CMD_SPD) begin
                    pollMode_q <= 1'b0;
                end
            end
        end
    end

    logic txSend;
    assign txSend = (state_q == ST_IDLE) && !atnT && !ifcActive && talkAddr_q && !davT
                    && (pollMode_q || txValid) && !nrfdT;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q    <= ST_IDLE;
            byte_q     <= 8'h00;
            eoiLatch_q <= 1'b0;
            atnLatch_q <= 1'b0;
            sentLf_q   <= 1'b0;
            nrfdN_oe   <= 1'b0;
            ndacN_oe   <= 1'b0;
            davN_oe    <= 1'b0;
            eoiN_oe    <= 1'b0;
            dioN_oe    <= 1'b0;
            dioN_o     <= 8'hFF;
            txReady    <= 1'b0;
        end else if (clkEn) begin
            txReady <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    davN_oe  <= 1'b0;
                    eoiN_oe  <= 1'b0;
                    dioN_oe  <= 1'b0;
                    nrfdN_oe <= !(atnT || (listenAddr_q && bufInReady)) && (atnT || listenAddr_q);
                    ndacN_oe <= atnT || listenAddr_q;
                    if (rxTake) begin
                        byte_q     <= dioT;
                        eoiLatch_q <= eoiT;
                        atnLatch_q <= atnT;
                        nrfdN_oe   <= 1'b1;
                        ndacN_oe   <= 1'b0;
                        state_q    <= ST_RXACK;
                    end else if (txSend) begin
                        dioN_o   <= pollMode_q ? ~statusIn : ~txData;
                        eoiN_oe  <= !pollMode_q && txLast;
                        sentLf_q <= !pollMode_q && txLast;
                        dioN_oe  <= 1'b1;
                        davN_oe  <= 1'b1;
                        txReady  <= !pollMode_q;
                        state_q  <= ST_TXDAV;
                    end
                end
                ST_RXACK: begin
                    if (!davT && (!dataByte || bufInReady)) begin
                        ndacN_oe <= 1'b1;
                        state_q  <= ST_IDLE;
                    end
                end
                ST_TXDAV: begin
                    if (!ndacT || atnT) begin
                        davN_oe <= 1'b0;
                        state_q <= ST_TXEND;
                    end
                end
                default: begin
                    dioN_oe <= 1'b0;
                    eoiN_oe <= 1'b0;
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign nrfdN_o = 1'b0;
    assign ndacN_o = 1'b0;
    assign davN_o  = 1'b0;
    assign eoiN_o  = 1'b0;

    logic rxPop;
    assign rxPop = bufOutValid && rxReady;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rxData   <= 8'h00;
            rxValid  <= 1'b0;
            cmdEnd   <= 1'b0;
            msgEnd   <= 1'b0;
            prevLf_q <= 1'b0;
        end else if (clkEn) begin
            rxValid <= rxPop;
            rxData  <= bufOutData[7:0];
            // The end mark comes only from each byte's own EOI bit, so a CR after an LF ends the message only if it carries EOI.
            msgEnd  <= rxPop && bufOutData[8];
            cmdEnd  <= rxPop && (bufOutData[7:0] == gmp_pkg::CHAR_SEMI || bufOutData[8]
                                 || isTerm(bufOutData[7:0]));
            if (rxPop) begin
                prevLf_q <= bufOutData[7:0] == gmp_pkg::CHAR_LF;
            end
        end
    end

    logic newCmd, respDone;
    assign newCmd   = rxPop && !prevLf_q;
    assign respDone = (state_q == ST_TXEND) && sentLf_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            mav_q    <= 1'b0;
            outFlush <= 1'b0;
            errValid <= 1'b0;
            errCode  <= 10'h000;
        end else if (clkEn) begin
            outFlush <= 1'b0;
            errValid <= 1'b0;
            if (execFail) begin
                mav_q    <= 1'b1;
                errValid <= 1'b1;
                errCode  <= gmp_pkg::ERR_TIMEOUT;
            end else if (respReady) begin
                mav_q <= 1'b1;
            end else if (mav_q && newCmd) begin
                mav_q    <= 1'b0;
                outFlush <= 1'b1;
                errValid <= 1'b1;
                errCode  <= gmp_pkg::ERR_QUERY_INT;
            end else if (respDone) begin
                mav_q <= 1'b0;
            end
        end
    end

    // The response source gives LF as its last byte, and txLast then drives EOI.

    poll_no_eoi_a: assert property (@(posedge core_clk) disable iff (reset)
        (davN_oe && pollMode_q) |-> !eoiN_oe) else $error("EOI during status byte.");

    last_eoi_a: assert property (@(posedge core_clk) disable iff (reset)
        (clkEn && txSend && !pollMode_q && txLast) |=> eoiN_oe) else $error("Last byte lacks EOI.");

    resp_end_lf_a: assert property (@(posedge core_clk) disable iff (reset)
        (davN_oe && eoiN_oe) |-> dioN_o == ~gmp_pkg::CHAR_LF) else $error("Response end is not LF.");

    ifc_clear_a: assert property (@(posedge core_clk) disable iff (reset)
        (clkEn && ifcActive) |=> !listenAddr_q && !talkAddr_q && !pollMode_q) else $error("IFC did not clear.");

    listen_addr_a: assert property (@(posedge core_clk) disable iff (reset)
        (clkEn && rxTake && atnT && !ifcActive && dioT == gmp_pkg::LISTEN_BASE + {3'h0, addr_q}) |=> listenAddr_q)
        else $error("Listen address missed.");

    cmd_ack_a: assert property (@(posedge core_clk) disable iff (reset)
        (clkEn && state_q == ST_IDLE && davT && atnT) |=> state_q == ST_RXACK)
        else $error("Command byte not acknowledged.");

    data_ignore_a: assert property (@(posedge core_clk) disable iff (reset)
        (clkEn && state_q == ST_IDLE && !atnT && !listenAddr_q) |=> !ndacN_oe && !nrfdN_oe)
        else $error("Unaddressed data handshaked.");

    dav_wait_a: assert property (@(posedge core_clk) disable iff (reset)
        $rose(davN_oe) |-> !$past(nrfdT)) else $error("DAV before NRFD release.");

    mav_set_a: assert property (@(posedge core_clk) disable iff (reset)
        (clkEn && execFail) |=> mav_q && errCode == gmp_pkg::ERR_TIMEOUT) else $error("Timeout not flagged.");

    mav_flush_a: assert property (@(posedge core_clk) disable iff (reset)
        (clkEn && mav_q && newCmd && !execFail && !respReady) |=> !mav_q && outFlush)
        else $error("Query interrupt not handled.");
endmodule : gmp_message_port

// File: gmp_pkg.sv
package gmp_pkg;
    localparam logic [7:0] CHAR_LF      = 8'h0A;
    localparam logic [7:0] CHAR_CR      = 8'h0D;
    localparam logic [7:0] CHAR_SEMI    = 8'h3B;
    localparam logic [7:0] LISTEN_BASE  = 8'h20;
    localparam logic [7:0] TALK_BASE    = 8'h40;
    localparam logic [7:0] CMD_UNL      = 8'h3F;
    localparam logic [7:0] CMD_UNT      = 8'h5F;
    localparam logic [7:0] CMD_SPE      = 8'h18;
    localparam logic [7:0] CMD_SPD      = 8'h19;
    localparam int         MAV_BIT      = 4;
    localparam logic [4:0] ADDR_RESET   = 5'h05;
    localparam logic [4:0] ADDR_MAX     = 5'h1E;
    localparam logic [7:0] STB_RESET    = 8'h00;
    localparam logic [9:0] ERR_QUERY_INT = 10'h19A;
    localparam logic [9:0] ERR_TIMEOUT   = 10'h16D;
    localparam int         SYNC_STAGES  = 2;
endpackage : gmp_pkg

// File: gmp_sync.sv
`timescale 1ns/10ps
module gmp_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             clkEn,
    input  wire logic [WIDTH-1:0] resetVal,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            stage1_q <= resetVal;
            syncOut  <= resetVal;
        end else if (clkEn) begin
            stage1_q <= asyncIn;
            syncOut  <= stage1_q;
        end
    end
endmodule : gmp_sync

// File: gmp_buf2.sv
`timescale 1ns/10ps
module gmp_buf2 #(
    parameter int WIDTH = 9
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             clkEn,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    logic [WIDTH-1:0] mem_q [2];
    logic             wrPtr_q;
    logic             rdPtr_q;
    logic [1:0]       count_q;
    logic             doWr;
    logic             doRd;

    assign inReady  = (count_q != 2'h2);
    assign outValid = (count_q != 2'h0);
    assign outData  = mem_q[rdPtr_q];
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wrPtr_q <= 1'b0;
            rdPtr_q <= 1'b0;
            count_q <= 2'h0;
        end else if (clkEn) begin
            if (doWr) begin
                mem_q[wrPtr_q] <= inData;
                wrPtr_q        <= ~wrPtr_q;
            end
            if (doRd) begin
                rdPtr_q <= ~rdPtr_q;
            end
            if (doWr && !doRd) begin
                count_q <= count_q + 2'h1;
            end else if (doRd && !doWr) begin
                count_q <= count_q - 2'h1;
            end
        end
    end
endmodule : gmp_buf2

// File: gmp_ctrl_model.sv
`timescale 1ns/10ps
module gmp_ctrl_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] dioLineN,
    input  wire logic       davLineN,
    input  wire logic       nrfdLineN,
    input  wire logic       ndacLineN,
    input  wire logic       eoiLineN,
    output logic      [7:0] cDioN,
    output logic            cDavOe,
    output logic            cNrfdOe,
    output logic            cNdacOe,
    output logic            cEoiOe,
    output logic            atnN,
    output logic            ifcN
);
    int nTimeouts;

    initial begin
        cDioN = 8'hFF;
        {cDavOe, cNrfdOe, cNdacOe, cEoiOe} = 4'h0;
        {atnN, ifcN} = 2'h3;
        nTimeouts = 0;
    end

    // A line that never reaches the level is counted rather than hanging the bus.
    task automatic waitFor(input int sel, input logic lvl);
        int n;
        n = 0;
        while ((sel == 0 ? nrfdLineN : sel == 1 ? ndacLineN : davLineN) !== lvl && n < 300) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n == 300) nTimeouts++;
    endtask : waitFor

    task automatic sendByte(input logic [7:0] b, input logic atn, input logic eoi);
        @(posedge core_clk);
        #1;
        cNrfdOe = 1'b0;
        cNdacOe = 1'b0;
        atnN    = ~atn;
        // A listener must hold NDAC before DAV may go out, else the byte is lost unseen.
        waitFor(1, 1'b0);
        waitFor(0, 1'b1);
        cDioN   = ~b;
        cEoiOe  = eoi;
        @(posedge core_clk);
        #1;
        cDavOe  = 1'b1;
        @(posedge core_clk);
        #1;
        waitFor(1, 1'b1);
        cDavOe  = 1'b0;
        @(posedge core_clk);
        #1;
        cDioN   = 8'hFF;
        cEoiOe  = 1'b0;
    endtask : sendByte

    // The listener keeps not-ready asserted afterwards so the next byte waits for the next read.
    task automatic readByte(output logic [7:0] b, output logic eoi, input int dly);
        @(posedge core_clk);
        #1;
        atnN    = 1'b1;
        cNdacOe = 1'b1;
        cNrfdOe = 1'b0;
        waitFor(2, 1'b0);
        b       = ~dioLineN;
        eoi     = ~eoiLineN;
        cNrfdOe = 1'b1;
        repeat (dly) @(posedge core_clk);
        #1;
        cNdacOe = 1'b0;
        waitFor(2, 1'b1);
        cNdacOe = 1'b1;
    endtask : readByte

    task automatic clearBus;
        @(posedge core_clk);
        #1;
        ifcN = 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        ifcN = 1'b1;
    endtask : clearBus
endmodule : gmp_ctrl_model

// File: gmp_message_port_bench.sv
`timescale 1ns/10ps
module gmp_message_port_bench;
    logic            core_clk, reset, clkEn, rxValid, rxReady, cmdEnd, msgEnd, txLast, txValid, txReady;
    logic            respReady, execFail, outFlush, errValid, listenAddr_q, talkAddr_q, pollMode_q, mav_q;
    logic            dioN_oe, davN_o, davN_oe, nrfdN_o, nrfdN_oe, ndacN_o, ndacN_oe, eoiN_o, eoiN_oe;
    logic            atnN_i, ifcN_i, cDavOe, cNrfdOe, cNdacOe, cEoiOe;
    logic      [4:0] busAddr;
    logic      [7:0] dioN_o, cDioN, rxData, txData, statusIn;
    logic      [9:0] errCode, lastErr;
    logic      [9:0] rxQ[$];
    int              n_errors, n_compared, nFlush;
    // Open-drain lines with pull-ups: low when any party drives low.
    wire logic [7:0] dioN_i  = (dioN_oe ? dioN_o : 8'hFF) & cDioN;
    wire logic       davN_i  = (davN_oe ? davN_o : 1'b1) & ~cDavOe;
    wire logic       nrfdN_i = (nrfdN_oe ? nrfdN_o : 1'b1) & ~cNrfdOe;
    wire logic       ndacN_i = (ndacN_oe ? ndacN_o : 1'b1) & ~cNdacOe;
    wire logic       eoiN_i  = (eoiN_oe ? eoiN_o : 1'b1) & ~cEoiOe;

    assign statusIn = {3'b010, mav_q, 4'h3};

    gmp_message_port dut (
        .core_clk, .reset, .clkEn, .busAddr, .dioN_i, .dioN_o, .dioN_oe, .davN_i, .davN_o, .davN_oe,
        .nrfdN_i, .nrfdN_o, .nrfdN_oe, .ndacN_i, .ndacN_o, .ndacN_oe, .eoiN_i, .eoiN_o, .eoiN_oe,
        .atnN_i, .ifcN_i, .rxData, .rxValid, .rxReady, .cmdEnd, .msgEnd, .txData, .txLast, .txValid,
        .txReady, .respReady, .execFail, .statusIn, .outFlush, .errValid, .errCode, .listenAddr_q,
        .talkAddr_q, .pollMode_q, .mav_q
    );

    gmp_ctrl_model ctrl (
        .core_clk, .dioLineN(dioN_i), .davLineN(davN_i), .nrfdLineN(nrfdN_i), .ndacLineN(ndacN_i),
        .eoiLineN(eoiN_i), .cDioN, .cDavOe, .cNrfdOe, .cNdacOe, .cEoiOe, .atnN(atnN_i), .ifcN(ifcN_i)
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (rxValid === 1'b1) rxQ.push_back({msgEnd, cmdEnd, rxData});
        if (errValid === 1'b1) lastErr = errCode;
        if (outFlush === 1'b1) nFlush++;
    end

    task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic cmd(input logic [7:0] b);
        ctrl.sendByte(b, 1'b1, 1'b0);
    endtask : cmd

    task automatic pulseIn(input logic fail);
        @(posedge core_clk);
        #1;
        respReady = ~fail;
        execFail  = fail;
        @(posedge core_clk);
        #1;
        respReady = 1'b0;
        execFail  = 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : pulseIn

    task automatic sendTx(input logic [7:0] b, input logic last);
        int n;
        n = 0;
        @(posedge core_clk);
        #1;
        txData  = b;
        txLast  = last;
        txValid = 1'b1;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (txReady !== 1'b1 && n < 500);
        txValid = 1'b0;
        if (txReady !== 1'b1) begin
            n_errors++;
            $display("wrong value at %0t: reply byte not taken", $time);
        end
    endtask : sendTx

    task automatic s_listen;
        logic [9:0] exp [8];
        exp = '{10'h041, 10'h13B, 10'h042, 10'h30A, 10'h043, 10'h10A, 10'h30D, 10'h344};
        cmd(gmp_pkg::CMD_UNL);
        cmd(gmp_pkg::LISTEN_BASE + 8'h07);
        chk(10'(listenAddr_q), 10'h001, "listen address");
        rxQ.delete();
        foreach (exp[i]) ctrl.sendByte(exp[i][7:0], 1'b0, exp[i][9]);
        repeat (10) @(posedge core_clk);
        chk(10'(rxQ.size()), 10'h008, "received count");
        foreach (exp[i]) chk(rxQ[i], exp[i], "received byte");
    endtask : s_listen

    task automatic s_stall;
        @(posedge core_clk);
        #1;
        rxQ.delete();
        rxReady = 1'b0;
        ctrl.sendByte(8'h31, 1'b0, 1'b0);
        ctrl.sendByte(8'h32, 1'b0, 1'b0);
        fork
            ctrl.sendByte(8'h33, 1'b0, 1'b1);
        join_none
        repeat (40) @(posedge core_clk);
        #1;
        chk(10'(nrfdN_i), 10'h000, "not ready while full");
        chk(10'(rxQ.size()), 10'h000, "delivered while stalled");
        clkEn   = 1'b0;
        rxReady = 1'b1;
        repeat (10) @(posedge core_clk);
        #1;
        chk(10'(rxQ.size()), 10'h000, "delivered while frozen");
        chk(10'(nrfdN_i), 10'h000, "not ready while frozen");
        clkEn   = 1'b1;
        wait fork;
        repeat (10) @(posedge core_clk);
        chk(10'(rxQ.size()), 10'h003, "drained count");
        chk(rxQ[2], 10'h333, "last drained byte");
    endtask : s_stall

    task automatic s_poll;
        logic [7:0] b;
        logic       e;
        pulseIn(1'b0);
        chk(10'(mav_q), 10'h001, "ready flag");
        cmd(gmp_pkg::CMD_UNL);
        cmd(gmp_pkg::TALK_BASE + 8'h07);
        cmd(gmp_pkg::CMD_SPE);
        chk(10'(pollMode_q), 10'h001, "poll mode on");
        ctrl.readByte(b, e, 0);
        chk(10'(b), 10'h053, "status byte");
        chk(10'(e), 10'h000, "status end flag");
        cmd(gmp_pkg::CMD_SPD);
        chk(10'(pollMode_q), 10'h000, "poll mode off");
        chk(10'(mav_q), 10'h001, "flag kept over poll");
        fork
            begin
                sendTx(8'h37, 1'b0);
                sendTx(gmp_pkg::CHAR_LF, 1'b1);
            end
        join_none
        ctrl.readByte(b, e, 0);
        chk({e, 1'b0, b}, 10'h037, "first reply byte");
        ctrl.readByte(b, e, 6);
        chk({e, 1'b0, b}, 10'h20A, "last reply byte");
        wait fork;
        repeat (5) @(posedge core_clk);
        chk(10'(mav_q), 10'h000, "flag after reply");
    endtask : s_poll

    task automatic s_intr;
        int f0;
        pulseIn(1'b0);
        f0 = nFlush;
        cmd(gmp_pkg::LISTEN_BASE + 8'h07);
        ctrl.sendByte(8'h58, 1'b0, 1'b1);
        repeat (5) @(posedge core_clk);
        chk(10'(nFlush - f0), 10'h001, "buffer discarded");
        chk(lastErr, gmp_pkg::ERR_QUERY_INT, "interrupt error");
        chk(10'(mav_q), 10'h000, "flag dropped");
        pulseIn(1'b1);
        chk(10'(mav_q), 10'h001, "flag after failure");
        chk(lastErr, gmp_pkg::ERR_TIMEOUT, "timeout error");
    endtask : s_intr

    task automatic s_refuse;
        ctrl.clearBus();
        repeat (4) @(posedge core_clk);
        chk({7'h0, listenAddr_q, talkAddr_q, pollMode_q}, 10'h000, "interface clear");
        rxQ.delete();
        ctrl.sendByte(8'h5A, 1'b0, 1'b1);
        repeat (5) @(posedge core_clk);
        chk(10'(rxQ.size()), 10'h000, "byte to unaddressed device");
    endtask : s_refuse

    task automatic test_done;
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    initial begin
        {reset, clkEn, rxReady} = 3'h7;
        {txLast, txValid, respReady, execFail} = 4'h0;
        busAddr = 5'h07;
        txData = 8'h00;
        n_errors = 0;
        n_compared = 0;
        nFlush = 0;
        repeat (20) @(posedge core_clk);
        #1;
        reset = 1'b0;
        repeat (3) @(posedge core_clk);
        s_listen();
        s_stall();
        s_poll();
        s_intr();
        chk(10'(ctrl.nTimeouts), 10'h000, "handshake stalled");
        s_refuse();
        test_done();
    end

    // The scenarios need under a thousand cycles; this bound leaves wide margin.
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        test_done();
    end
endmodule : gmp_message_port_bench
